// [rtl/psc_power_ctrl.sv]
// Power-save modes, doze control and clock fail-over of the core.
`timescale 1ns/1ps
// Function
// [R1] Fail-safe monitor enable comes only from a strap caught after reset.
// [R2] With the monitor on, low-power RC runs outside Sleep regardless.
// [R3] Missing oscillator raises a clock-failure trap and selects fast RC.
// [R4] Failing while on a PLL source falls back to fast RC through PLL.
// [R5] Power-save with sleep operand stops clocks and halts execution.
// [R6] Power-save with idle operand halts CPU; peripherals keep clock.
// [R7] Enabled interrupt, watchdog time-out or reset wakes Sleep or Idle.
// [R8] Sleep shuts the selected source and its on-chip oscillator.
// [R9] Fail-safe monitor is inactive during Sleep.
// [R10] In Sleep low-power RC runs while the watchdog is enabled.
// [R11] Watchdog counter is cleared on entry to Sleep and to Idle.
// [R12] Sleep stops system-clocked peripherals; external and change logic run.
// [R13] Wake from Sleep resumes on the clock source used before.
// [R14] Idle keeps the system clock and peripheral clocks running.
// [R15] In Idle low-power RC runs if watchdog or monitor is enabled.
// [R16] Wake from Idle restores the CPU clock at once.
// [R17] Interrupt coincident with power-save waits for entry, then wakes.
// [R18] Doze divides only the CPU clock; peripherals stay at full rate.
// [R19] Doze is active while slowdown-enable bit 11 is set.
// [R20] Bits 14:12 pick eight CPU ratios from 1:1 to 1:128.
// [R21] Return-on-interrupt bit 15 lets an interrupt end doze.
// [R22] Software picks a new oscillator in bits 10:8 while unlocked.
// [R23] Unprogrammed switch config bit disables monitor and switching.
// [R24] Ratio codes are powers of two, 000 is 1:1, 111 is 1:128.
module psc_power_ctrl
  import psc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clock_switch_config_bit,
  input wire logic i_fail_safe_monitor_prog,
  input wire logic [OSC_W-1:0] i_startup_osc,
  input wire logic i_osc_beat,
  input wire logic [REG_W-1:0] i_osc_control_reg,
  input wire logic i_osc_switch_req,
  input wire logic [REG_W-1:0] i_clock_divider_reg,
  input wire logic i_power_save_instr,
  input wire logic i_power_save_sleep,
  input wire logic i_irq_pending,
  input wire logic i_watchdog_timer_en,
  input wire logic i_watchdog_timer_timeout,
  output logic [OSC_W-1:0] o_sys_clk_sel,
  output logic o_sys_clk_src_on,
  output logic o_fast_rc_osc_en,
  output logic o_pll_en,
  output logic o_low_power_rc_osc_en,
  output logic o_clk_fail_trap,
  output logic o_clk_failed,
  output logic o_cpu_clk_en,
  output logic o_periph_clk_en,
  output logic o_ext_clk_periph_en,
  output logic o_change_notify_en,
  output logic o_watchdog_timer_clear,
  output logic o_sleep_active,
  output logic o_idle_active,
  output logic o_wake
);

  psc_ctl_if ctl ();

  // Heartbeat and strap synchroniser stages.
  logic beat_s1;
  logic beat_s2;
  logic beat_s3;
  logic cfg_s1;
  logic cfg_s2;
  logic prog_s1;
  logic prog_s2;
  logic [OSC_W-1:0] start_s1;
  logic [OSC_W-1:0] start_s2;

  // The first stage feeds only the second; edges come from stages 2 and 3.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      beat_s1 <= 1'b0;
      beat_s2 <= 1'b0;
      beat_s3 <= 1'b0;
      cfg_s1 <= CFG_SW_DISABLED;
      cfg_s2 <= CFG_SW_DISABLED;
      prog_s1 <= 1'b0;
      prog_s2 <= 1'b0;
      start_s1 <= OSC_FRC;
      start_s2 <= OSC_FRC;
    end else begin
      beat_s1 <= i_osc_beat;
      beat_s2 <= beat_s1;
      beat_s3 <= beat_s2;
      cfg_s1 <= i_clock_switch_config_bit;
      cfg_s2 <= cfg_s1;
      prog_s1 <= i_fail_safe_monitor_prog;
      prog_s2 <= prog_s1;
      start_s1 <= i_startup_osc;
      start_s2 <= start_s1;
    end
  end

  // Configuration capture: straps are caught once, after the synchroniser
  // has settled, so no runtime write can change them later.
  logic [1:0] cfg_cnt;
  logic [1:0] next_cfg_cnt;
  logic cfg_done;
  logic next_cfg_done;
  logic switch_ok;
  logic next_switch_ok;
  logic mon_cfg;
  logic next_mon_cfg;

  always_comb begin
    next_cfg_cnt = cfg_cnt;
    next_cfg_done = cfg_done;
    next_switch_ok = switch_ok;
    next_mon_cfg = mon_cfg;
    if (!cfg_done) begin
      if (cfg_cnt == CFG_SETTLE) begin
        next_cfg_done = 1'b1;
        next_switch_ok = (cfg_s2 != CFG_SW_DISABLED); // see [R23]
        next_mon_cfg = (cfg_s2 != CFG_SW_DISABLED) && prog_s2; // see [R1]
      end else begin
        next_cfg_cnt = cfg_cnt + CFG_ONE;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cfg_cnt <= CFG_ZERO;
      cfg_done <= 1'b0;
      switch_ok <= 1'b0;
      mon_cfg <= 1'b0;
    end else begin
      cfg_cnt <= next_cfg_cnt;
      cfg_done <= next_cfg_done;
      switch_ok <= next_switch_ok;
      mon_cfg <= next_mon_cfg;
    end
  end

  // Power-save sequencer.
  psc_state_e state;
  psc_state_e next_state;
  logic sleep_sel;
  logic next_sleep_sel;
  logic wake;
  logic next_wake;

  // An interrupt during the entry cycle is not looked at; its pending level
  // is still there one cycle later and wakes the part from the new mode.
  always_comb begin
    next_state = state;
    next_sleep_sel = sleep_sel;
    next_wake = 1'b0;
    case (state)
      PS_RUN: begin
        if (i_power_save_instr && cfg_done) begin
          next_state = PS_ENTER;
          next_sleep_sel = i_power_save_sleep; // see [R5] [R6]
        end
      end
      PS_ENTER: begin
        next_state = sleep_sel ? PS_SLEEP : PS_IDLE; // see [R17]
      end
      PS_SLEEP, PS_IDLE: begin
        if (i_irq_pending || i_watchdog_timer_timeout) begin
          next_state = PS_RUN; // see [R7] [R16]
          next_wake = 1'b1;
        end
      end
      default: begin
        next_state = PS_RUN;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state <= PS_RUN;
      sleep_sel <= 1'b0;
      wake <= 1'b0;
    end else begin
      state <= next_state;
      sleep_sel <= next_sleep_sel;
      wake <= next_wake;
    end
  end

  // Active source selection and fail-over latch.
  logic [OSC_W-1:0] cur_osc;
  logic [OSC_W-1:0] next_cur_osc;
  logic failed;
  logic next_failed;
  logic [OSC_W-1:0] req_osc;

  always_comb begin
    req_osc = i_osc_control_reg[OSC_NEXT_MSB:OSC_NEXT_LSB]; // see [R22]
    next_cur_osc = cur_osc;
    next_failed = failed | ctl.fail_pulse;
    if (!cfg_done) begin
      next_cur_osc = start_s2;
    end else if (ctl.fail_pulse) begin
      // Keep the PLL in the path so the multiplied rate is preserved.
      if (cur_osc == OSC_PRI_PLL || cur_osc == OSC_FRC_PLL) begin
        next_cur_osc = OSC_FRC_PLL; // see [R4]
      end else begin
        next_cur_osc = OSC_FRC; // see [R3]
      end
    end else if (switch_ok && i_osc_switch_req && state == PS_RUN) begin
      next_cur_osc = req_osc; // see [R23]
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cur_osc <= OSC_FRC;
      failed <= 1'b0;
    end else begin
      cur_osc <= next_cur_osc; // see [R13]
      failed <= next_failed;
    end
  end

  // Doze cancel: an interrupt with return-on-interrupt set ends doze until
  // software drops the slowdown bit, as the bit itself is owned outside.
  logic doze_cancel;
  logic next_doze_cancel;
  logic slow_en;
  logic ret_irq;

  always_comb begin
    slow_en = i_clock_divider_reg[DIV_SLOW_BIT]; // see [R19]
    ret_irq = i_clock_divider_reg[DIV_RET_IRQ_BIT];
    next_doze_cancel = 1'b0;
    if (slow_en) begin
      next_doze_cancel = doze_cancel | (i_irq_pending & ret_irq); // see [R21]
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      doze_cancel <= 1'b0;
    end else begin
      doze_cancel <= next_doze_cancel;
    end
  end

  // Links out. The monitor stops before the sleep edge, so that no late
  // trap can move the source while the part sleeps.
  assign ctl.beat_edge = beat_s2 ^ beat_s3;
  assign ctl.mon_enable = mon_cfg && !failed &&
                          next_state != PS_SLEEP; // see [R9]
  assign ctl.doze_active = slow_en && !doze_cancel; // see [R19]
  assign ctl.doze_ratio = i_clock_divider_reg[DIV_RATIO_MSB:DIV_RATIO_LSB];
  assign ctl.cpu_halt = next_state != PS_RUN || !next_cfg_done;

  psc_fail_mon u_mon (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .ctl(ctl)
  );

  psc_doze_div u_doze (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .ctl(ctl)
  );

  // Outputs are registered from the next state so they line up with it.
  logic next_asleep;
  logic next_src_on;

  always_comb begin
    next_asleep = next_state == PS_SLEEP;
    next_src_on = !next_asleep; // see [R8] [R14]
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_sys_clk_sel <= OSC_FRC;
      o_sys_clk_src_on <= 1'b1;
      o_fast_rc_osc_en <= 1'b1;
      o_pll_en <= 1'b0;
      o_low_power_rc_osc_en <= 1'b0;
      o_clk_fail_trap <= 1'b0;
      o_clk_failed <= 1'b0;
      o_periph_clk_en <= 1'b1;
      o_ext_clk_periph_en <= 1'b1;
      o_change_notify_en <= 1'b1;
      o_watchdog_timer_clear <= 1'b0;
      o_sleep_active <= 1'b0;
      o_idle_active <= 1'b0;
      o_wake <= 1'b0;
    end else begin
      o_sys_clk_sel <= next_cur_osc;
      o_sys_clk_src_on <= next_src_on; // see [R8]
      o_fast_rc_osc_en <= next_src_on && (next_cur_osc == OSC_FRC ||
                          next_cur_osc == OSC_FRC_PLL); // see [R8]
      o_pll_en <= next_src_on && (next_cur_osc == OSC_FRC_PLL ||
                  next_cur_osc == OSC_PRI_PLL); // see [R4]
      // Watchdog keeps it in every mode; the monitor keeps it awake only.
      o_low_power_rc_osc_en <= i_watchdog_timer_en ||
        (next_mon_cfg && !next_asleep); // see [R2] [R10] [R15]
      o_clk_fail_trap <= ctl.fail_pulse; // see [R3]
      o_clk_failed <= next_failed;
      o_periph_clk_en <= next_src_on; // see [R12] [R14] [R18]
      o_ext_clk_periph_en <= 1'b1; // see [R12]
      o_change_notify_en <= 1'b1; // see [R12]
      o_watchdog_timer_clear <= next_state == PS_ENTER; // see [R11]
      o_sleep_active <= next_asleep;
      o_idle_active <= next_state == PS_IDLE;
      o_wake <= next_wake;
    end
  end

  assign o_cpu_clk_en = ctl.cpu_en;

  default clocking top_cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  chk_mon_cfg_fixed: assert property ( // see [R1]
    cfg_done && $past(cfg_done) |-> $stable(mon_cfg) && $stable(switch_ok))
    else $error("monitor configuration changed after capture");

  chk_low_power_rc_osc_monitor: assert property ( // see [R2]
    mon_cfg && !o_sleep_active |-> o_low_power_rc_osc_en)
    else $error("low-power RC stopped while monitor enabled");

  chk_fail_trap: assert property ( // see [R3]
    ctl.fail_pulse && cur_osc != OSC_PRI_PLL && cur_osc != OSC_FRC_PLL
    |=> o_clk_fail_trap && cur_osc == OSC_FRC && o_sys_clk_sel == OSC_FRC)
    else $error("failure did not trap and select fast RC");

  chk_fail_pll: assert property ( // see [R4]
    ctl.fail_pulse && cur_osc == OSC_PRI_PLL
    |=> cur_osc == OSC_FRC_PLL && o_pll_en)
    else $error("PLL fail-over lost the multiplier");

  chk_sleep_halt: assert property ( // see [R5]
    state == PS_SLEEP |-> !o_cpu_clk_en && !o_sys_clk_src_on &&
    !o_periph_clk_en && o_ext_clk_periph_en)
    else $error("clocks running in sleep");

  chk_idle_periph: assert property ( // see [R6]
    state == PS_IDLE |-> !o_cpu_clk_en && o_periph_clk_en && o_sys_clk_src_on)
    else $error("idle clocks wrong");

  chk_wake_event: assert property ( // see [R7]
    (state == PS_SLEEP || state == PS_IDLE) &&
    (i_irq_pending || i_watchdog_timer_timeout)
    |=> state == PS_RUN && o_wake ##1 o_cpu_clk_en)
    else $error("wake event did not resume the CPU");

  chk_wdt_clear: assert property ( // see [R11]
    $rose(o_sleep_active) || $rose(o_idle_active)
    |-> $past(o_watchdog_timer_clear) && !o_watchdog_timer_clear)
    else $error("watchdog not cleared on entry");

  chk_irq_defer: assert property ( // see [R17]
    state == PS_ENTER |=> state == PS_SLEEP || state == PS_IDLE)
    else $error("entry interrupted before completion");

  chk_sleep_osc: assert property ( // see [R13]
    state == PS_SLEEP |=> $stable(cur_osc))
    else $error("clock source changed during sleep");

  chk_low_power_rc_osc_wdt: assert property ( // see [R10]
    i_watchdog_timer_en |=> o_low_power_rc_osc_en)
    else $error("low-power RC off with watchdog enabled");

  cov_sleep_wake: cover property (state == PS_SLEEP ##1 state == PS_RUN);
  cov_idle_wake: cover property (state == PS_IDLE ##1 state == PS_RUN);
  cov_fail_trap: cover property (o_clk_fail_trap);
  cov_doze_irq: cover property (slow_en && ret_irq && $rose(doze_cancel));

endmodule // psc_power_ctrl

// [rtl/psc_pkg.sv]
// Shared constants, codes and state type of the power-save and clock block.
package psc_pkg;

  // System clock period and fail-safe detection window.
  localparam int CLK_PERIOD_NS = 8;
  localparam int FAIL_TIMEOUT_NS = 1000;
  // A least time: round up to whole cycles.
  localparam int FAIL_TIMEOUT_CYC =
    (FAIL_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MON_CNT_W = 8;
  localparam logic [MON_CNT_W-1:0] MON_LIMIT = MON_CNT_W'(FAIL_TIMEOUT_CYC);
  localparam logic [MON_CNT_W-1:0] MON_ONE = 8'h01;
  localparam logic [MON_CNT_W-1:0] MON_ZERO = 8'h00;

  // Oscillator source codes.
  localparam int OSC_W = 3;
  localparam logic [OSC_W-1:0] OSC_FRC = 3'h0;
  localparam logic [OSC_W-1:0] OSC_FRC_PLL = 3'h1;
  localparam logic [OSC_W-1:0] OSC_PRI = 3'h2;
  localparam logic [OSC_W-1:0] OSC_PRI_PLL = 3'h3;
  localparam logic [OSC_W-1:0] OSC_SEC = 3'h4;
  localparam logic [OSC_W-1:0] OSC_LOW_POWER_RC_OSC = 3'h5;

  // Field positions in the clock divider and oscillator control words.
  localparam int REG_W = 16;
  localparam int DIV_RET_IRQ_BIT = 15;
  localparam int DIV_RATIO_MSB = 14;
  localparam int DIV_RATIO_LSB = 12;
  localparam int DIV_SLOW_BIT = 11;
  localparam int OSC_NEXT_MSB = 10;
  localparam int OSC_NEXT_LSB = 8;

  // Doze ratio field and divider counter.
  localparam int RATIO_W = 3;
  localparam int DOZE_CNT_W = 8;
  localparam logic [DOZE_CNT_W-1:0] DOZE_ONE = 8'h01;
  localparam logic [DOZE_CNT_W-1:0] DOZE_ZERO = 8'h00;

  // Configuration strap handling.
  localparam logic CFG_SW_DISABLED = 1'b1;
  localparam logic [1:0] CFG_SETTLE = 2'h2;
  localparam logic [1:0] CFG_ZERO = 2'h0;
  localparam logic [1:0] CFG_ONE = 2'h1;

  typedef enum logic [1:0] {
    PS_RUN,
    PS_ENTER,
    PS_SLEEP,
    PS_IDLE
  } psc_state_e;

endpackage

// [rtl/psc_ctl_if.sv]
// Internal carrier between the controller, fail monitor and doze divider.
`timescale 1ns/1ps
interface psc_ctl_if;
  import psc_pkg::*;
  logic mon_enable;
  logic beat_edge;
  logic fail_pulse;
  logic doze_active;
  logic [RATIO_W-1:0] doze_ratio;
  logic cpu_halt;
  logic cpu_en;

  modport top (output mon_enable, output beat_edge, input fail_pulse,
               output doze_active, output doze_ratio, output cpu_halt,
               input cpu_en);
  modport mon (input mon_enable, input beat_edge, output fail_pulse);
  modport doze (input doze_active, input doze_ratio, input cpu_halt,
                output cpu_en);
endinterface

// [rtl/psc_fail_mon.sv]
// Watches the active oscillator heartbeat and flags a missing clock.
`timescale 1ns/1ps
module psc_fail_mon
  import psc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  psc_ctl_if.mon ctl
);

  logic [MON_CNT_W-1:0] silent_cnt;
  logic [MON_CNT_W-1:0] next_silent_cnt;
  logic fail;
  logic next_fail;

  // Count cycles without a heartbeat edge; only one trap per silence.
  always_comb begin
    next_silent_cnt = silent_cnt;
    next_fail = 1'b0;
    if (!ctl.mon_enable || ctl.beat_edge) begin
      next_silent_cnt = MON_ZERO;
    end else if (silent_cnt == MON_LIMIT - MON_ONE) begin
      next_silent_cnt = MON_LIMIT;
      next_fail = 1'b1; // see [R3]
    end else if (silent_cnt != MON_LIMIT) begin
      next_silent_cnt = silent_cnt + MON_ONE;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      silent_cnt <= MON_ZERO;
      fail <= 1'b0;
    end else begin
      silent_cnt <= next_silent_cnt;
      fail <= next_fail;
    end
  end

  assign ctl.fail_pulse = fail;

  default clocking mon_cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  chk_mon_timeout: assert property ( // see [R3]
    ctl.mon_enable && !ctl.beat_edge && silent_cnt == MON_LIMIT - MON_ONE
    |=> fail)
    else $error("monitor missed the heartbeat time-out");

  chk_mon_quiet: assert property (
    !ctl.mon_enable |=> !fail)
    else $error("monitor flagged a failure while disabled");

endmodule // psc_fail_mon

// [rtl/psc_doze_div.sv]
// Divides the CPU clock enable by a power of two while peripherals run on.
`timescale 1ns/1ps
module psc_doze_div
  import psc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  psc_ctl_if.doze ctl
);

  logic [DOZE_CNT_W-1:0] cnt;
  logic [DOZE_CNT_W-1:0] next_cnt;
  logic [DOZE_CNT_W-1:0] lim;
  logic en;
  logic next_en;

  // Ratio code n gives one CPU enable every 2**n cycles.
  always_comb begin
    lim = (DOZE_ONE << ctl.doze_ratio) - DOZE_ONE; // see [R24] [R20]
    next_cnt = DOZE_ZERO;
    next_en = 1'b0;
    if (!ctl.cpu_halt) begin
      if (!ctl.doze_active || cnt >= lim) begin
        next_en = 1'b1;
      end else begin
        next_cnt = cnt + DOZE_ONE; // see [R18]
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cnt <= DOZE_ZERO;
      en <= 1'b0;
    end else begin
      cnt <= next_cnt;
      en <= next_en;
    end
  end

  assign ctl.cpu_en = en;

  default clocking doze_cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  chk_doze_halves: assert property ( // see [R20]
    en && ctl.doze_active && !ctl.cpu_halt && ctl.doze_ratio == 3'h1
    ##1 (ctl.doze_active && !ctl.cpu_halt && ctl.doze_ratio == 3'h1)
    |-> !en ##1 en)
    else $error("doze ratio 1:2 not kept");

  chk_doze_full: assert property ( // see [R21]
    !ctl.doze_active && !ctl.cpu_halt |=> en)
    else $error("CPU not at full speed outside doze");

  cov_doze_slow: cover property (
    ctl.doze_active && ctl.doze_ratio == 3'h7 && en);

endmodule // psc_doze_div

// [bench/psc_osc_model.sv]
// Behavioural oscillator source that sends a heartbeat while it runs.
`timescale 1ns/1ps
module psc_osc_model (
  input wire logic i_src_on,
  input wire logic i_kill,
  output logic o_beat
);
  // The beat freezes when the source is shut down or broken, as a dead
  // crystal would, so the monitor sees a real loss and not a lucky toggle.
  initial begin
    o_beat = 1'b0;
    forever begin
      #12;
      if (i_src_on && !i_kill) begin
        o_beat = !o_beat;
      end
    end
  end
endmodule // psc_osc_model

// [bench/tb_top.sv]
// Self-checking bench for the power-save and clock fail-over block.
`timescale 1ns/1ps
module tb_top;
  import psc_pkg::*;
  logic clk, rst_n, cfg_bit, mon_prog, beat, sw_req, ps, ps_sleep, kill;
  logic irq, wdt_en, wdt_to, src_on, frc_en, pll_en, low_power_rc_osc_en, trap, failed;
  logic cpu_en, per_en, ext_en, cn_en, wdt_clr, slp, idl, wake;
  logic [OSC_W-1:0] start_osc, sel;
  logic [REG_W-1:0] osc_ctl, div;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;

  psc_osc_model osc (.i_src_on(src_on), .i_kill(kill), .o_beat(beat));

  psc_power_ctrl DUT (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_clock_switch_config_bit(cfg_bit),
    .i_fail_safe_monitor_prog(mon_prog), .i_startup_osc(start_osc),
    .i_osc_beat(beat), .i_osc_control_reg(osc_ctl), .i_osc_switch_req(sw_req),
    .i_clock_divider_reg(div), .i_power_save_instr(ps),
    .i_power_save_sleep(ps_sleep), .i_irq_pending(irq),
    .i_watchdog_timer_en(wdt_en), .i_watchdog_timer_timeout(wdt_to),
    .o_sys_clk_sel(sel), .o_sys_clk_src_on(src_on), .o_fast_rc_osc_en(frc_en),
    .o_pll_en(pll_en), .o_low_power_rc_osc_en(low_power_rc_osc_en),
    .o_clk_fail_trap(trap), .o_clk_failed(failed), .o_cpu_clk_en(cpu_en),
    .o_periph_clk_en(per_en), .o_ext_clk_periph_en(ext_en),
    .o_change_notify_en(cn_en), .o_watchdog_timer_clear(wdt_clr),
    .o_sleep_active(slp), .o_idle_active(idl), .o_wake(wake));

  // Free-running 125 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH time=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the few thousand cycles the run needs.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // Inputs change only at the falling edge, away from the sampling edge.
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic count(input int len, output int n, output int p);
    n = 0;
    p = 0;
    repeat (len) begin
      cyc(1);
      n = n + ((cpu_en === 1'b1) ? 1 : 0);
      p = p + ((per_en === 1'b1) ? 1 : 0);
    end
  endtask

  // Reset for six cycles, then wait past strap capture before any request.
  task automatic do_reset(input logic cfg, input logic [OSC_W-1:0] osc);
    rst_n = 1'b0;
    cfg_bit = cfg;
    start_osc = osc;
    kill = 1'b0;
    cyc(6);
    check({sel, src_on, frc_en, pll_en, per_en, ext_en, cn_en, cpu_en},
          {OSC_FRC, 7'h6e});
    rst_n = 1'b1;
    cyc(5);
    check({sel, cpu_en}, {osc, 1'b1});
  endtask

  // Enter Sleep or Idle, stay a while, wake by interrupt or watchdog.
  task automatic ps_cycle(input logic s, input logic by_wdt, input int hold,
                          input logic exp_low_power_rc_osc);
    logic [OSC_W-1:0] was_sel = sel;
    logic [1:0] was_osc = {frc_en, pll_en};
    ps = 1'b1;
    ps_sleep = s;
    cyc(1);
    ps = 1'b0;
    check({wdt_clr, cpu_en}, 2'h2);
    cyc(1);
    check({wdt_clr, slp, idl, cpu_en}, {1'b0, s, !s, 1'b0});
    check({src_on, per_en, ext_en, cn_en}, {!s, !s, 2'h3});
    check({frc_en, pll_en}, s ? 2'h0 : was_osc);
    check(low_power_rc_osc_en, exp_low_power_rc_osc);
    cyc(hold);
    check({slp, idl}, {s, !s});
    if (by_wdt) begin
      wdt_to = 1'b1;
    end else begin
      irq = 1'b1;
    end
    cyc(1);
    wdt_to = 1'b0;
    irq = 1'b0;
    check({slp, idl, wake, src_on}, 4'h3);
    cyc(1);
    check({cpu_en, sel}, {1'b1, was_sel});
  endtask

  // Interrupt arrives together with the power-save instruction.
  task automatic coincide();
    logic saw_s = 1'b0;
    logic saw_w = 1'b0;
    ps = 1'b1;
    ps_sleep = 1'b1;
    irq = 1'b1;
    cyc(1);
    ps = 1'b0;
    check(slp, 1'b0);
    repeat (4) begin
      cyc(1);
      saw_s = saw_s | (slp === 1'b1);
      saw_w = saw_w | (wake === 1'b1);
    end
    irq = 1'b0;
    check({saw_s, saw_w, slp}, 3'h6);
  endtask

  // Every ratio code: CPU enables per 256 cycles halve at each step.
  task automatic doze_ratios();
    int n;
    int p;
    for (int r = 0; r < 8; r++) begin
      div = {1'b0, 3'(r), 1'b1, 11'h000};
      cyc(300);
      count(256, n, p);
      check(16'(n), 16'(256 >> r));
      check(16'(p), 16'h0100);
    end
    div = 16'h0000;
  endtask

  // Interrupt during doze at 1:8, with and without return-on-interrupt.
  task automatic doze_irq(input logic [REG_W-1:0] d, input int exp);
    int n;
    int p;
    div = d;
    cyc(20);
    irq = 1'b1;
    cyc(1);
    irq = 1'b0;
    cyc(3);
    count(64, n, p);
    check(16'(n), 16'(exp));
    div = 16'h0000;
    cyc(2);
  endtask

  // Switching and the monitor are off; a broken source goes unnoticed.
  task automatic locked_checks();
    check(low_power_rc_osc_en, 1'b0);
    osc_ctl = {5'h00, OSC_PRI_PLL, 8'h00};
    sw_req = 1'b1;
    cyc(1);
    sw_req = 1'b0;
    cyc(2);
    check(sel, OSC_PRI);
    kill = 1'b1;
    cyc(200);
    check({trap, failed, sel}, {2'h0, OSC_PRI});
    kill = 1'b0;
  endtask

  // Switch to a PLL source, then break it and expect the trap.
  task automatic fail_over();
    int n = 0;
    osc_ctl = {5'h00, OSC_PRI_PLL, 8'h00};
    sw_req = 1'b1;
    cyc(1);
    sw_req = 1'b0;
    cyc(2);
    check({sel, pll_en, low_power_rc_osc_en}, {OSC_PRI_PLL, 2'h3});
    cyc(10);
    kill = 1'b1;
    while (trap !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
    check(16'(n > 120 && n < 140), 16'h0001);
    check({sel, pll_en, frc_en}, {OSC_FRC_PLL, 2'h3});
    cyc(1);
    check({trap, failed}, 2'h1);
  endtask

  // Main sequence: locked configuration first, then monitor enabled.
  initial begin
    {ps, ps_sleep, irq, wdt_en, wdt_to, sw_req, kill} = 7'h00;
    osc_ctl = 16'h0000;
    div = 16'h0000;
    mon_prog = 1'b1;
    do_reset(1'b1, OSC_PRI);
    locked_checks();
    doze_ratios();
    doze_irq(16'hb800, 64);
    doze_irq(16'h3800, 8);
    ps_cycle(1'b0, 1'b0, 3, 1'b0);
    wdt_en = 1'b1;
    cyc(2);
    ps_cycle(1'b1, 1'b1, 5, 1'b1);
    coincide();
    wdt_en = 1'b0;
    do_reset(1'b0, OSC_PRI);
    ps_cycle(1'b0, 1'b1, 3, 1'b1);
    wdt_en = 1'b1;
    cyc(2);
    ps_cycle(1'b1, 1'b0, 150, 1'b1);
    check(failed, 1'b0);
    wdt_en = 1'b0;
    fail_over();
    give_verdict();
  end
endmodule // tb_top
